// file: include/llcr_defs.svh
`ifndef LLCR_DEFS_SVH
`define LLCR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define LLCR_ADDR_OPMODE      7'h01
`define LLCR_ADDR_OSC         7'h0A
`define LLCR_ADDR_AFC         7'h0B
`define LLCR_ADDR_LOWBAT      7'h0C
`define LLCR_ADDR_LISTEN1     7'h0D
`define LLCR_ADDR_LISTEN2     7'h0E
`define LLCR_ADDR_LISTEN3     7'h0F
`define LLCR_ADDR_VERSION     7'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LLCR_BIT_LISTEN_ON    6
`define LLCR_BIT_LISTEN_ABORT 5
`define LLCR_POS_MODE         2
`define LLCR_BIT_CAL_START    7
`define LLCR_BIT_CAL_DONE     6
`define LLCR_BIT_AFC_LOW      5
`define LLCR_BIT_BAT_MONITOR  4
`define LLCR_BIT_BAT_ON       3
`define LLCR_POS_BAT_TRIM     0
`define LLCR_POS_IDLE_UNIT    6
`define LLCR_POS_RX_UNIT      4
`define LLCR_BIT_CRITERIA     3
`define LLCR_POS_END_ACTION   1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LLCR_RST_MODE         3'h1
`define LLCR_RST_BAT_TRIM     3'h2
`define LLCR_RST_IDLE_UNIT    2'h2
`define LLCR_RST_RX_UNIT      2'h1
`define LLCR_RST_END_ACTION   2'h1
`define LLCR_RST_IDLE_COEF    8'hF5
`define LLCR_RST_RX_COEF      8'h20
// Revision value is arbitrary.
`define LLCR_REVISION         8'h11

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LLCR_CLK_PERIOD_PS    8000
`define LLCR_UNIT_BASE_US     64
`define LLCR_UNIT_BASE_CYCLES (`LLCR_UNIT_BASE_US * 1000000 / `LLCR_CLK_PERIOD_PS)
`define LLCR_RES_STEP         6'h3F
`define LLCR_RC_CAL_US        100
`define LLCR_RC_CAL_CYCLES    (`LLCR_RC_CAL_US * 1000000 / `LLCR_CLK_PERIOD_PS)

`endif

// file: include/llcr_pkg.sv
package llcr_pkg;

  typedef enum logic [2:0] {
    LLCR_SLEEP   = 3'h0,
    LLCR_STANDBY = 3'h1,
    LLCR_SYNTH   = 3'h2,
    LLCR_RECEIVE = 3'h4
  } llcr_mode_type;

  typedef enum logic [2:0] {
    LS_OFF     = 3'h0,
    LS_IDLE    = 3'h1,
    LS_RX      = 3'h2,
    LS_HOLD    = 3'h3,
    LS_STAY    = 3'h4,
    LS_STOPPED = 3'h5
  } llcr_listen_state_type;

endpackage

// file: include/llcr_reg_if.sv
`timescale 1ns/1ps
interface llcr_reg_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;

  modport port (output addr, output wdata, output wr, output rd, input rdata);
  modport bank (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// file: design/llcr_serial_port.sv
`timescale 1ns/1ps
`include "llcr_defs.svh"
module llcr_serial_port (
  input  wire logic  mclk,
  input  wire logic  rst,
  input  wire logic  sck,
  input  wire logic  nss_n,
  input  wire logic  mosi,
  output logic       miso,
  llcr_reg_if.port   bus
);
  logic [2:0] sck_sync;
  logic [1:0] nss_sync;
  logic [1:0] mosi_sync;
  logic [2:0] bit_count;
  logic [6:0] rx_shift;
  logic [7:0] tx_shift;
  logic [6:0] addr;
  logic       first_byte;
  logic       is_write;
  logic       step;
  logic       rd;
  logic [7:0] wdata;

  wire        active    = ~nss_sync[1];
  wire        sck_rise  = sck_sync[1] & ~sck_sync[2];
  wire        sck_fall  = ~sck_sync[1] & sck_sync[2];
  wire [7:0]  rx_byte   = {rx_shift, mosi_sync[1]};
  wire        byte_done = active & sck_rise & (bit_count == 3'h7);

  assign bus.addr  = addr;
  assign bus.wdata = wdata;
  assign bus.wr    = step & is_write;
  assign bus.rd    = rd;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_sync  <= 3'h0;
      nss_sync  <= 2'h3;
      mosi_sync <= 2'h0;
    end else begin
      sck_sync  <= {sck_sync[1:0], sck};
      nss_sync  <= {nss_sync[0], nss_n};
      mosi_sync <= {mosi_sync[0], mosi};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_count  <= 3'h0;
      rx_shift   <= 7'h00;
      first_byte <= 1'b1;
      is_write   <= 1'b0;
      addr       <= 7'h00;
      wdata      <= 8'h00;
      step       <= 1'b0;
      rd         <= 1'b0;
    end else begin
      step <= byte_done & ~first_byte;
      rd   <= (byte_done & first_byte & ~rx_byte[7]) | (step & ~is_write);
      if (!active) begin
        bit_count  <= 3'h0;
        first_byte <= 1'b1;
      end else if (sck_rise) begin
        bit_count <= bit_count + 3'h1;
        rx_shift  <= rx_byte[6:0];
      end
      if (byte_done && first_byte) begin
        addr       <= rx_byte[6:0];
        is_write   <= rx_byte[7];
        first_byte <= 1'b0;
      end else if (byte_done) begin
        wdata <= rx_byte;
      end
      if (step) begin
        addr <= addr + 7'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_shift <= 8'h00;
      miso     <= 1'b0;
    end else if (!active) begin
      miso <= 1'b0;
    end else if (rd) begin
      miso     <= bus.rdata[7];
      tx_shift <= {bus.rdata[6:0], 1'b0};
    end else if (sck_fall && bit_count != 3'h0) begin
      miso     <= tx_shift[7];
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end
endmodule

// file: design/llcr_phase_timer.sv
`timescale 1ns/1ps
`include "llcr_defs.svh"
module llcr_phase_timer #(
  parameter int unsigned UNIT_BASE_CYCLES = `LLCR_UNIT_BASE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [1:0] unit_sel,
  input  wire logic [7:0] coef,
  output logic            expired
);
  logic [23:0] base_count;
  logic [5:0]  mid_count;
  logic [5:0]  long_count;
  logic [7:0]  tick_count;
  logic [7:0]  target;
  logic [1:0]  unit;
  logic        running;

  wire base_tick = running & (base_count == 24'(UNIT_BASE_CYCLES - 1));
  wire mid_tick  = base_tick & (mid_count == `LLCR_RES_STEP);
  wire long_tick = mid_tick & (long_count == `LLCR_RES_STEP);
  wire unit_tick = (unit == 2'h3) ? long_tick : (unit == 2'h2) ? mid_tick : base_tick;
  wire done_now  = running & (tick_count == target);

  // ----------------------------------------------------------------------------
  // Every phase restarts the whole prescaler chain.
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      base_count <= 24'h0;
      mid_count  <= 6'h0;
      long_count <= 6'h0;
      tick_count <= 8'h00;
      target     <= 8'h00;
      unit       <= 2'h1;
      running    <= 1'b0;
      expired    <= 1'b0;
    end else if (start) begin
      base_count <= 24'h0;
      mid_count  <= 6'h0;
      long_count <= 6'h0;
      tick_count <= 8'h00;
      target     <= coef;
      unit       <= unit_sel;
      running    <= 1'b1;
      expired    <= 1'b0;
    end else begin
      expired <= done_now;
      if (done_now) begin
        running <= 1'b0;
      end
      base_count <= base_tick ? 24'h0 : (running ? base_count + 24'h1 : base_count);
      if (base_tick) begin
        mid_count <= mid_count + 6'h1;
      end
      if (mid_tick) begin
        long_count <= long_count + 6'h1;
      end
      if (unit_tick && !done_now) begin
        tick_count <= tick_count + 8'h01;
      end
    end
  end
endmodule

// file: design/llcr_config_regs.sv
`timescale 1ns/1ps
`include "llcr_defs.svh"
module llcr_config_regs
  import llcr_pkg::*;
#(
  parameter int unsigned UNIT_BASE_CYCLES = `LLCR_UNIT_BASE_CYCLES,
  parameter int unsigned RC_CAL_CYCLES    = `LLCR_RC_CAL_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       spi_sck,
  input  wire logic       spi_nss_n,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  input  wire logic       battery_comparator_raw,
  input  wire logic       signal_strength_limit,
  input  wire logic       sync_word_match,
  input  wire logic       payload_complete_event,
  input  wire logic       rx_timeout_event,
  output logic [2:0]      chip_mode,
  output logic            duty_cycle_active,
  output logic            afc_low_index_select,
  output logic            battery_detector_enable,
  output logic [2:0]      battery_threshold_select,
  output logic            rc_calibration_running,
  output logic            fifo_discard
);

  // ----------------------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------------------
  // The port turns host frames into register strobes.
  llcr_reg_if regs ();

  llcr_serial_port u_port (
    .mclk  (mclk),
    .rst   (rst),
    .sck   (spi_sck),
    .nss_n (spi_nss_n),
    .mosi  (spi_mosi),
    .miso  (spi_miso),
    .bus   (regs.port)
  );

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  // Software-visible fields.
  logic [2:0]            mode_request;
  logic                  duty_cycle_enable;
  logic [1:0]            idle_time_unit;
  logic [1:0]            receive_time_unit;
  logic                  packet_accept_rule;
  logic [1:0]            post_accept_action;
  logic [7:0]            idle_time_multiplier;
  logic [7:0]            receive_time_multiplier;

  // Status and sequencer state.
  logic [23:0]           cal_count;
  logic [1:0]            battery_sync;
  logic                  discard_pending;

  llcr_listen_state_type state;
  llcr_listen_state_type next_state;
  logic                  next_start_idle;
  logic                  next_start_rx;
  logic                  next_discard_pending;
  logic                  phase_expired;

  // ----------------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------------
  // One compare serves the write strobes and the read mux.
  function automatic logic hit(input logic [6:0] addr, input logic [6:0] target);
    hit = (addr == target);
  endfunction

  // Write strobes, one per writable register.
  wire wr_opmode  = regs.wr & hit(regs.addr, `LLCR_ADDR_OPMODE);
  wire wr_osc     = regs.wr & hit(regs.addr, `LLCR_ADDR_OSC);
  wire wr_afc     = regs.wr & hit(regs.addr, `LLCR_ADDR_AFC);
  wire wr_lowbat  = regs.wr & hit(regs.addr, `LLCR_ADDR_LOWBAT);
  wire wr_listen1 = regs.wr & hit(regs.addr, `LLCR_ADDR_LISTEN1);
  wire wr_listen2 = regs.wr & hit(regs.addr, `LLCR_ADDR_LISTEN2);
  wire wr_listen3 = regs.wr & hit(regs.addr, `LLCR_ADDR_LISTEN3);

  // Abort only counts when enable is cleared in the same write.
  wire listen_abort = wr_opmode & regs.wdata[`LLCR_BIT_LISTEN_ABORT] & ~regs.wdata[`LLCR_BIT_LISTEN_ON];
  wire cal_busy     = (cal_count != 24'h0);

  // A start is dropped while busy or outside standby.
  wire cal_start    = wr_osc & regs.wdata[`LLCR_BIT_CAL_START] & ~cal_busy & (chip_mode == LLCR_STANDBY);

  // The comparator is read only after two flops.
  wire battery_live = battery_detector_enable & battery_sync[1];

  // Acceptance is judged on every receive cycle.
  wire accept_now   = signal_strength_limit & (~packet_accept_rule | sync_word_match);

  // Either event ends the receive after an accept.
  wire rx_finished  = payload_complete_event | rx_timeout_event;

  // ----------------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_request      <= `LLCR_RST_MODE;
      duty_cycle_enable <= 1'b0;
    end else if (wr_opmode) begin
      mode_request      <= regs.wdata[`LLCR_POS_MODE +: 3];
      // Clearing it alone leaves a running cycle as is.
      duty_cycle_enable <= regs.wdata[`LLCR_BIT_LISTEN_ON];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      afc_low_index_select <= 1'b0;
    end else if (wr_afc) begin
      // Only the routine select bit is stored.
      afc_low_index_select <= regs.wdata[`LLCR_BIT_AFC_LOW];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      battery_detector_enable  <= 1'b0;
      battery_threshold_select <= `LLCR_RST_BAT_TRIM;
    end else if (wr_lowbat) begin
      // The monitor bit is read-only here.
      battery_detector_enable  <= regs.wdata[`LLCR_BIT_BAT_ON];
      battery_threshold_select <= regs.wdata[`LLCR_POS_BAT_TRIM +: 3];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idle_time_unit     <= `LLCR_RST_IDLE_UNIT;
      receive_time_unit  <= `LLCR_RST_RX_UNIT;
      packet_accept_rule <= 1'b0;
      post_accept_action <= `LLCR_RST_END_ACTION;
    end else if (wr_listen1) begin
      idle_time_unit     <= regs.wdata[`LLCR_POS_IDLE_UNIT +: 2];
      receive_time_unit  <= regs.wdata[`LLCR_POS_RX_UNIT +: 2];
      packet_accept_rule <= regs.wdata[`LLCR_BIT_CRITERIA];
      // Reserved codes are kept; the sequencer runs them as 01.
      post_accept_action <= regs.wdata[`LLCR_POS_END_ACTION +: 2];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idle_time_multiplier    <= `LLCR_RST_IDLE_COEF;
      receive_time_multiplier <= `LLCR_RST_RX_COEF;
    end else begin
      if (wr_listen2) begin
        idle_time_multiplier <= regs.wdata;
      end
      if (wr_listen3) begin
        receive_time_multiplier <= regs.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // RC calibration and battery comparator
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cal_count <= 24'h0;
    end else if (cal_start) begin
      // The length is a fixed count of mclk cycles.
      cal_count <= 24'(RC_CAL_CYCLES);
    end else if (cal_busy) begin
      cal_count <= cal_count - 24'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      battery_sync <= 2'h0;
    end else begin
      // Two flops guard against a changing analog level.
      battery_sync <= {battery_sync[0], battery_comparator_raw};
    end
  end

  // The done bit reads as the inverse of this flag.
  assign rc_calibration_running = cal_busy;

  // ----------------------------------------------------------------------------
  // Listen sequencer
  // ----------------------------------------------------------------------------
  // Unit and multiplier are taken at a phase start only.
  wire       timer_start = next_start_idle | next_start_rx;
  wire [1:0] timer_unit  = next_start_rx ? receive_time_unit : idle_time_unit;
  wire [7:0] timer_coef  = next_start_rx ? receive_time_multiplier : idle_time_multiplier;

  llcr_phase_timer #(
    .UNIT_BASE_CYCLES (UNIT_BASE_CYCLES)
  ) u_timer (
    .mclk     (mclk),
    .rst      (rst),
    .start    (timer_start),
    .unit_sel (timer_unit),
    .coef     (timer_coef),
    .expired  (phase_expired)
  );

  always_comb begin
    next_state           = state;
    next_start_idle      = 1'b0;
    next_start_rx        = 1'b0;
    next_discard_pending = discard_pending;
    case (state)
      LS_OFF: begin
        // A pending discard does not survive leaving listen.
        next_discard_pending = 1'b0;
        if (duty_cycle_enable && !listen_abort) begin
          next_state      = LS_IDLE;
          next_start_idle = 1'b1;
        end
      end

      LS_IDLE: begin
        if (listen_abort) begin
          next_state = LS_OFF;
        end else if (phase_expired) begin
          next_state           = LS_RX;
          next_start_rx        = 1'b1;
          next_discard_pending = 1'b0;
        end
      end

      // An abort wins over an accept or an expiry.
      LS_RX: begin
        if (listen_abort) begin
          next_state = LS_OFF;
        end else if (accept_now) begin
          if (post_accept_action == 2'h0) begin
            next_state = LS_STAY;
          end else begin
            next_state = LS_HOLD;
          end
        end else if (phase_expired) begin
          next_state      = LS_IDLE;
          next_start_idle = 1'b1;
        end
      end

      // Wait for the end of the accepted packet.
      LS_HOLD: begin
        if (listen_abort) begin
          next_state = LS_OFF;
        end else if (rx_finished && post_accept_action == 2'h2) begin
          next_state           = LS_IDLE;
          next_start_idle      = 1'b1;
          next_discard_pending = 1'b1;
        end else if (rx_finished) begin
          next_state = LS_STOPPED;
        end
      end

      // Only clearing the enable leaves a stopped listen.
      LS_STAY, LS_STOPPED: begin
        if (!duty_cycle_enable) begin
          next_state = LS_OFF;
        end
      end

      default: begin
        next_state = LS_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state           <= LS_OFF;
      discard_pending <= 1'b0;
      fifo_discard    <= 1'b0;
    end else begin
      state           <= next_state;
      discard_pending <= next_discard_pending;
      // The pulse marks the first wakeup after a resume.
      fifo_discard    <= next_start_rx & discard_pending;
    end
  end

  // ----------------------------------------------------------------------------
  // Current chip mode
  // ----------------------------------------------------------------------------
  // Every state with the receiver on reports receive.
  wire in_receive = (state == LS_RX) | (state == LS_HOLD) | (state == LS_STAY);

  // Idle sleeps; outside listen the request is current.
  assign chip_mode = in_receive ? LLCR_RECEIVE :
                     (state == LS_IDLE) ? LLCR_SLEEP : mode_request;

  // Listen is active until it stops or is left.
  assign duty_cycle_active = (state == LS_IDLE) | (state == LS_RX) | (state == LS_HOLD);

  // ----------------------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------------------
  // Write-only bits read 0.
  wire [7:0] rd_opmode  = {1'b0, duty_cycle_enable, 1'b0, chip_mode, 2'h0};
  wire [7:0] rd_osc     = {1'b0, ~cal_busy, 6'h00};
  wire [7:0] rd_afc     = {2'h0, afc_low_index_select, 5'h00};
  wire [7:0] rd_lowbat  = {3'h0, battery_live, battery_detector_enable, battery_threshold_select};
  wire [7:0] rd_listen1 = {idle_time_unit, receive_time_unit, packet_accept_rule, post_accept_action, 1'b0};

  // Unmapped addresses read 0.
  assign regs.rdata = hit(regs.addr, `LLCR_ADDR_OPMODE)  ? rd_opmode  :
                      hit(regs.addr, `LLCR_ADDR_OSC)     ? rd_osc     :
                      hit(regs.addr, `LLCR_ADDR_AFC)     ? rd_afc     :
                      hit(regs.addr, `LLCR_ADDR_LOWBAT)  ? rd_lowbat  :
                      hit(regs.addr, `LLCR_ADDR_LISTEN1) ? rd_listen1 :
                      hit(regs.addr, `LLCR_ADDR_LISTEN2) ? idle_time_multiplier :
                      hit(regs.addr, `LLCR_ADDR_LISTEN3) ? receive_time_multiplier :
                      hit(regs.addr, `LLCR_ADDR_VERSION) ? `LLCR_REVISION : 8'h00;

endmodule

// file: bench/llcr_host_model.sv
`timescale 1ns/1ps
module llcr_host_model #(
  parameter int HALF = 10
) (
  input  wire logic mclk,
  output logic      sck,
  output logic      nss_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck = 1'b0;
    nss_n = 1'b1;
    mosi = 1'b0;
  end

  // Shifts one byte out MSB first in mode 0 and collects miso at each rise.
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      repeat (HALF) @(negedge mclk);
      sck = 1'b1;
      rx[i] = miso;
      repeat (HALF) @(negedge mclk);
      sck = 1'b0;
    end
  endtask

  task automatic access(input logic wnr, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] dummy;
    @(negedge mclk);
    nss_n = 1'b0;
    shift({wnr, a}, dummy);
    shift(wd, rd);
    repeat (HALF) @(negedge mclk);
    nss_n = 1'b1;
    // A released data line must not keep showing its last bit.
    mosi = ~mosi;
    repeat (2 * HALF) @(negedge mclk);
  endtask
endmodule

// file: bench/llcr_config_regs_sva.sv
`timescale 1ns/1ps
module llcr_config_regs_sva (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       spi_nss_n,
  input wire logic       spi_miso,
  input wire logic [2:0] chip_mode,
  input wire logic       duty_cycle_active,
  input wire logic       afc_low_index_select,
  input wire logic       battery_detector_enable,
  input wire logic [2:0] battery_threshold_select,
  input wire logic       rc_calibration_running,
  input wire logic       fifo_discard
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_reset_vals;
    $fell(rst) |-> battery_threshold_select == 3'h2 && !battery_detector_enable && chip_mode == 3'h1;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  property p_mode_legal;
    chip_mode inside {3'h0, 3'h1, 3'h2, 3'h4};
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal mode code");
  property p_listen_mode;
    duty_cycle_active |-> chip_mode == 3'h0 || chip_mode == 3'h4;
  endproperty
  a_listen_mode: assert property (p_listen_mode) else $error("listen phase mode wrong");
  property p_discard_pulse;
    fifo_discard |-> duty_cycle_active ##1 !fifo_discard;
  endproperty
  a_discard_pulse: assert property (p_discard_pulse) else $error("discard pulse wrong");
  property p_cal_bound;
    $rose(rc_calibration_running) |-> ##[1:40] !rc_calibration_running;
  endproperty
  a_cal_bound: assert property (p_cal_bound) else $error("calibration never ends");
  property p_cal_standby;
    $rose(rc_calibration_running) |-> $past(chip_mode) == 3'h1;
  endproperty
  a_cal_standby: assert property (p_cal_standby) else $error("calibration outside standby");
  property p_regs_hold;
    spi_nss_n [*8] ##1 spi_nss_n |=> $stable({afc_low_index_select, battery_detector_enable, battery_threshold_select});
  endproperty
  a_regs_hold: assert property (p_regs_hold) else $error("register changed without access");
  property p_miso_idle;
    spi_nss_n [*6] |-> !spi_miso;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso driven while deselected");
  property p_mode_hold;
    (spi_nss_n && !duty_cycle_active) [*8] |=> $stable(chip_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside listen");
endmodule

bind llcr_config_regs llcr_config_regs_sva i_llcr_config_regs_sva (.mclk(mclk), .rst(rst), .spi_nss_n(spi_nss_n),
  .spi_miso(spi_miso), .chip_mode(chip_mode), .duty_cycle_active(duty_cycle_active),
  .afc_low_index_select(afc_low_index_select), .battery_detector_enable(battery_detector_enable),
  .battery_threshold_select(battery_threshold_select), .rc_calibration_running(rc_calibration_running),
  .fifo_discard(fifo_discard));

// file: bench/test_listen_lowbat_config_regs.sv
`timescale 1ns/1ps
`include "llcr_defs.svh"
module test_listen_lowbat_config_regs
  import llcr_pkg::*;
;
  logic       mclk, rst, sck, nss_n, mosi, miso, bat, rssi, sync, pay, tmo;
  logic       act, afc, bat_en, cal, fdis, saw_cal, saw_fd, crit, acc;
  logic [2:0] mode, trim;
  logic [6:0] a;
  logic [7:0] d, rv;
  int         err_count = 0, samples_checked = 0, seed = 32'h13b0;

  llcr_config_regs #(.UNIT_BASE_CYCLES(4), .RC_CAL_CYCLES(5)) i_llcr_config_regs (.mclk(mclk), .rst(rst),
    .spi_sck(sck), .spi_nss_n(nss_n), .spi_mosi(mosi), .spi_miso(miso), .battery_comparator_raw(bat),
    .signal_strength_limit(rssi), .sync_word_match(sync), .payload_complete_event(pay), .rx_timeout_event(tmo),
    .chip_mode(mode), .duty_cycle_active(act), .afc_low_index_select(afc), .battery_detector_enable(bat_en),
    .battery_threshold_select(trim), .rc_calibration_running(cal), .fifo_discard(fdis));
  llcr_host_model i_llcr_host_model (.mclk(mclk), .sck(sck), .nss_n(nss_n), .mosi(mosi), .miso(miso));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (cal) saw_cal <= 1'b1;
    if (fdis) saw_fd <= 1'b1;
  end

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] wa, input logic [7:0] wd);
    i_llcr_host_model.access(1'b1, wa, wd, rv);
  endtask
  task automatic rdchk(input logic [6:0] ra, input logic [7:0] exp);
    i_llcr_host_model.access(1'b0, ra, 8'h00, rv);
    check(rv, exp);
  endtask
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (mode !== m && n < 400) begin
      @(negedge mclk);
      n++;
    end
    check({5'h00, mode}, {5'h00, m});
    if (mode !== m) finish_test();
  endtask
  // Read-back value of a register after writing d, with unstored bits masked and the monitor bit taken from bat.
  function automatic logic [7:0] exp_rd(input logic [6:0] ea, input logic [7:0] ed);
    case (ea)
      7'h0B: exp_rd = ed & 8'h20;
      7'h0C: exp_rd = {3'h0, ed[3] & bat, ed[3:0]};
      7'h0D: exp_rd = ed & 8'hFE;
      default: exp_rd = ed;
    endcase
  endfunction

  initial begin
    {rst, bat, rssi, sync, pay, tmo, saw_cal, saw_fd} = 8'h80;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    check({bat_en, afc, trim, mode}, 8'h11);
    rdchk(7'h0A, 8'h40);
    rdchk(7'h0B, 8'h00);
    rdchk(7'h0C, 8'h02);
    rdchk(7'h0D, 8'h92);
    rdchk(7'h0E, 8'hF5);
    rdchk(7'h0F, 8'h20);
    rdchk(7'h10, `LLCR_REVISION);
    rdchk(7'h11, 8'h00);
    $display("test reset_values done");
    for (int k = 0; k < 12; k++) begin
      a = 7'h0B + 7'(k % 5);
      d = 8'($random(seed));
      bat = 1'($random(seed));
      wr(a, d);
      rdchk(a, exp_rd(a, d));
      if (a == 7'h0C) check({4'h0, bat_en, trim}, {4'h0, d[3:0]});
      if (a == 7'h0B) check({7'h00, afc}, {7'h00, d[5]});
    end
    wr(7'h10, 8'hFF);
    rdchk(7'h10, `LLCR_REVISION);
    $display("test random_access done");
    for (int m = 0; m < 5; m++) begin
      if (m != 3) wr(7'h01, 8'(m << 2));
      if (m != 3) rdchk(7'h01, 8'(m << 2));
    end
    wait_mode(3'h4);
    saw_cal = 1'b0;
    wr(7'h0A, 8'h80);
    check({7'h00, saw_cal}, 8'h00);
    wr(7'h01, 8'h04);
    wr(7'h0A, 8'h80);
    check({7'h00, saw_cal}, 8'h01);
    rdchk(7'h0A, 8'h40);
    $display("test calibration done");
    wr(7'h0E, 8'h02);
    wr(7'h0F, 8'h03);
    for (int e = 0; e < 3; e++) begin
      crit = (e != 0);
      wr(7'h0D, {4'h5, crit, 2'(e), 1'b0});
      {rssi, sync, saw_fd} = 3'b010;
      wr(7'h01, 8'h44);
      for (int j = 1; j < 4; j++) begin
        {rssi, sync} = 2'(j);
        wait_mode(3'h4);
        acc = rssi & (!crit | sync);
        if (acc) break;
        wait_mode(3'h0);
      end
      repeat (40) @(negedge mclk);
      check({4'h0, act, mode}, {4'h0, e != 0, 3'h4});
      {pay, tmo} = (e == 1) ? 2'b10 : 2'b01;
      @(negedge mclk);
      {pay, tmo} = 2'b00;
      if (e == 1) wait_mode(3'h1);
      if (e == 2) wait_mode(3'h0);
      if (e == 2) wait_mode(3'h4);
      @(negedge mclk);
      check({6'h00, act, saw_fd}, {6'h00, e == 2, e == 2});
      if (e < 2) wr(7'h01, 8'h04);
      else wr(7'h01, 8'h24);
      wait_mode(3'h1);
      check({7'h00, act}, 8'h00);
      $display("test listen end action %0d done", e);
    end
    finish_test();
  end
endmodule
